// >>> energy_pulse_output_select.sv
// Energy to pulse conversion, pulse pin select, stepper and watchdog
`timescale 1ns/1ps
`include "epo_defines.svh"
// Notes on behaviour
// - Integrate four power kinds into 20-bit energies
// - Energy becomes proportional pulse train, selectable
// - 3-phase active LSB always 1000/(C*2^10) Wh
// - Topology 3 doubles LSB weight for 3-phase Q, F, R
// - Peripheral mode: serial pins serve only communication
// - Mode zero: zero-cross on pos, watchdog neg
// - Watchdog: 16 ms pulse every 1.6 s
// - Latch request restarts the watchdog interval
// - Watchdog held high while supply is low
// - Mode zero: kind, fundamental, phase select pulse
// - Every selected pulse pin source runs at C
// - Mode one: stepper from 3-phase active energy
// - Mode one: pulse pin 3-phase, ratio ignored
// - Stepper pulse length and divide ratio, alternating
// - Negative power mode selects accumulation rule
// - No-load flag holds motor pins low in stepper modes
module energy_pulse_output_select #(
  parameter logic [28:0] WD_PERIOD_CYC = 29'(`EPO_WD_PERIOD_CYC),
  parameter logic [28:0] WD_PULSE_CYC = 29'(`EPO_WD_PULSE_CYC),
  parameter logic [25:0] STEP_SHORT_CYC = 26'(`EPO_STEP_SHORT_CYC),
  parameter logic [25:0] STEP_LONG_CYC = 26'(`EPO_STEP_LONG_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire epo_pkg::cfg_s cfg_i,
  input wire epo_pkg::power_s power_i,
  input wire logic power_valid_i,
  input wire logic no_load_flag_i,
  input wire logic zero_cross_sig_i,
  input wire logic supply_low_i,
  input wire logic serial_latch_pin_i,
  output logic energy_pulse_pin_o,
  output logic motor_pos_pin_o,
  output logic motor_neg_pin_o,
  output logic serial_comm_only_o,
  output logic [19:0] active_energy_o
);
  import epo_pkg::*;

  logic signed [17:0] inc [16];
  logic [15:0] bidir;
  logic [15:0] coarse;
  logic [15:0] pulses;
  logic [19:0] energy [16];

  function automatic logic signed [17:0] shape(input logic [15:0] v,
                                               input logic active,
                                               input logic [1:0] mode);
    logic signed [17:0] s;
    s = 18'($signed(v));
    if (active && mode == `EPO_NEG_ABSOLUTE && s < 0)
      s = -s;
    else if (active && mode == `EPO_NEG_FERRARIS1 && s < 0)
      s = 18'sh00000;
    return s;
  endfunction

  function automatic logic [11:0] step_div(input logic [1:0] ratio,
                                           input logic long_sel);
    logic [11:0] d;
    case (ratio)
      2'h0: d = `EPO_DIV_K0;
      2'h1: d = `EPO_DIV_K1;
      2'h2: d = `EPO_DIV_K2;
      default: d = `EPO_DIV_K3;
    endcase
    return long_sel ? 12'(d * `EPO_DIV_LONG_MULT) : d;
  endfunction

  // Kind order P, F, Q, R; channel = kind*4 + (0 3-ph, 1..3 R,S,T)
  always_comb
  begin
    logic [15:0] v;
    logic signed [17:0] sh;
    logic signed [17:0] sum;
    v = 16'h0000;
    sh = 18'sh00000;
    sum = 18'sh00000;
    for (int k = 0; k < 4; k++)
    begin
      sum = 18'sh00000;
      for (int ph = 0; ph < 3; ph++)
      begin
        case (k)
          0: v = power_i.act[ph];
          1: v = power_i.harmonic_only_sel_act[ph];
          2: v = power_i.react[ph];
          default: v = power_i.harmonic_only_sel_react[ph];
        endcase
        // accumulation rule on active kinds only
        sh = shape(v, k < 2, cfg_i.neg_power_mode);
        inc[k*4+ph+1] = sh;
        sum = sum + sh;
        bidir[k*4+ph+1] = (k >= 2) ||
                          (cfg_i.neg_power_mode == `EPO_NEG_SIGNED);
        coarse[k*4+ph+1] = 1'b0;
      end
      inc[k*4] = sum;
      bidir[k*4] = (k >= 2) || (cfg_i.neg_power_mode == `EPO_NEG_SIGNED);
      // topology 3 weighting, keeps P at 2^10
      coarse[k*4] = (k != 0) && (cfg_i.topology == `EPO_SYS_HALF_LSB);
    end
  end

  for (genvar c = 0; c < 16; c++)
  begin : g_int
    energy_integrator u_int (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .valid_i(power_valid_i),
      .inc_i(inc[c]),
      .bidir_i(bidir[c]),
      .coarse_i(coarse[c]),
      .energy_o(energy[c]),
      .pulse_o(pulses[c])
    );
  end
  assign active_energy_o = energy[0];

  // Pin synchronisers, first stage read only by second
  logic latch_s1_r, latch_s2_r, latch_s3_r;
  logic sup_s1_r, sup_s2_r;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      latch_s1_r <= 1'b0;
      latch_s2_r <= 1'b0;
      latch_s3_r <= 1'b0;
      sup_s1_r <= 1'b1;
      sup_s2_r <= 1'b1;
    end
    else
    begin
      latch_s1_r <= serial_latch_pin_i;
      latch_s2_r <= latch_s1_r;
      latch_s3_r <= latch_s2_r;
      sup_s1_r <= supply_low_i;
      sup_s2_r <= sup_s1_r;
    end
  end
  logic latch_edge;
  assign latch_edge = latch_s2_r && !latch_s3_r;

  // Watchdog; period counts low time so cycle totals 1.6 s
  wd_state_e wd_state_r, wd_state_nxt;
  logic [28:0] wd_cnt_r, wd_cnt_nxt;
  logic wd_out_r, wd_out_nxt;
  always_comb
  begin
    wd_state_nxt = wd_state_r;
    wd_cnt_nxt = wd_cnt_r;
    case (wd_state_r)
      WD_HOLD:
      begin
        wd_cnt_nxt = 29'h00000000;
        if (!sup_s2_r)
          wd_state_nxt = WD_COUNT;
      end
      WD_COUNT:
      begin
        if (latch_edge)
          wd_cnt_nxt = 29'h00000000;
        else if (wd_cnt_r == WD_PERIOD_CYC - WD_PULSE_CYC - 29'h1)
        begin
          wd_state_nxt = WD_PULSE;
          wd_cnt_nxt = 29'h00000000;
        end
        else
          wd_cnt_nxt = wd_cnt_r + 29'h1;
      end
      WD_PULSE:
      begin
        if (wd_cnt_r == WD_PULSE_CYC - 29'h1)
        begin
          wd_state_nxt = WD_COUNT;
          wd_cnt_nxt = 29'h00000000;
        end
        else
          wd_cnt_nxt = wd_cnt_r + 29'h1;
      end
      default:
        wd_state_nxt = WD_HOLD;
    endcase
    if (sup_s2_r)
      wd_state_nxt = WD_HOLD;
    wd_out_nxt = wd_state_nxt != WD_COUNT;
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wd_state_r <= WD_HOLD;
      wd_cnt_r <= 29'h00000000;
      wd_out_r <= 1'b1;
    end
    else
    begin
      wd_state_r <= wd_state_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      wd_out_r <= wd_out_nxt;
    end
  end

  // Stepper divider and mono-flop
  step_state_e step_state_r, step_state_nxt;
  logic [11:0] div_cnt_r, div_cnt_nxt;
  logic [25:0] mono_cnt_r, mono_cnt_nxt;
  logic coil_sel_r, coil_sel_nxt;
  logic p3_neg_r, p3_neg_nxt;
  logic step_mode, step_block, step_fire;
  assign step_mode = cfg_i.app_mode_sel != `EPO_MODE_PERIPH;
  // 3-phase Ferraris negative blocks stepper, no-load
  assign step_block = no_load_flag_i || (p3_neg_r &&
    cfg_i.neg_power_mode == `EPO_NEG_FERRARIS3);
  assign step_fire = step_mode && !step_block && pulses[0] &&
    div_cnt_r == step_div(cfg_i.motor_ratio_sel, cfg_i.reactive_len_sel)
    - 12'h001;
  always_comb
  begin
    step_state_nxt = step_state_r;
    div_cnt_nxt = div_cnt_r;
    mono_cnt_nxt = mono_cnt_r;
    coil_sel_nxt = coil_sel_r;
    p3_neg_nxt = p3_neg_r;
    if (power_valid_i)
      p3_neg_nxt = inc[0] < 0;
    if (!step_mode || step_block)
      div_cnt_nxt = 12'h000;
    else if (step_fire)
      div_cnt_nxt = 12'h000;
    else if (pulses[0])
      div_cnt_nxt = div_cnt_r + 12'h001;
    case (step_state_r)
      STEP_IDLE:
      begin
        mono_cnt_nxt = 26'h0000000;
        if (step_fire)
          step_state_nxt = STEP_ON;
      end
      STEP_ON:
      begin
        // pulse length by length select, then alternate coil
        if (mono_cnt_r == (cfg_i.reactive_len_sel ? STEP_LONG_CYC
                           : STEP_SHORT_CYC) - 26'h1)
        begin
          step_state_nxt = STEP_IDLE;
          coil_sel_nxt = !coil_sel_r;
        end
        else
          mono_cnt_nxt = mono_cnt_r + 26'h1;
      end
      default:
        step_state_nxt = STEP_IDLE;
    endcase
    if (!step_mode || step_block)
      step_state_nxt = STEP_IDLE;
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      step_state_r <= STEP_IDLE;
      div_cnt_r <= 12'h000;
      mono_cnt_r <= 26'h0000000;
      coil_sel_r <= 1'b0;
      p3_neg_r <= 1'b0;
    end
    else
    begin
      step_state_r <= step_state_nxt;
      div_cnt_r <= div_cnt_nxt;
      mono_cnt_r <= mono_cnt_nxt;
      coil_sel_r <= coil_sel_nxt;
      p3_neg_r <= p3_neg_nxt;
    end
  end

  // Output pins, all registered so selection changes never glitch
  logic [3:0] src_idx;
  logic led_r, led_nxt, mpos_r, mpos_nxt, mneg_r, mneg_nxt;
  logic ser_r, ser_nxt;
  logic coil_on;
  assign coil_on = step_state_r == STEP_ON && step_mode && !step_block;
  always_comb
  begin
    // mode zero kind and phase, other modes 3-phase only
    if (cfg_i.app_mode_sel == `EPO_MODE_PERIPH)
      src_idx = {cfg_i.reactive_len_sel, cfg_i.harmonic_only_sel,
                 cfg_i.motor_ratio_sel};
    else
      src_idx = {cfg_i.reactive_len_sel, cfg_i.harmonic_only_sel, 2'h0};
    led_nxt = pulses[src_idx];
    // zero-cross and watchdog on motor pins
    if (cfg_i.app_mode_sel == `EPO_MODE_PERIPH)
    begin
      mpos_nxt = zero_cross_sig_i;
      mneg_nxt = wd_out_nxt;
    end
    else
    begin
      mpos_nxt = coil_on && !coil_sel_r;
      mneg_nxt = coil_on && coil_sel_r;
    end
    ser_nxt = !cfg_i.app_mode_sel[1];
  end
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      led_r <= 1'b0;
      mpos_r <= 1'b0;
      mneg_r <= 1'b1;
      ser_r <= 1'b1;
    end
    else
    begin
      led_r <= led_nxt;
      mpos_r <= mpos_nxt;
      mneg_r <= mneg_nxt;
      ser_r <= ser_nxt;
    end
  end
  assign energy_pulse_pin_o = led_r;
  assign motor_pos_pin_o = mpos_r;
  assign motor_neg_pin_o = mneg_r;
  assign serial_comm_only_o = ser_r;

  no_load_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    no_load_flag_i && step_mode |=> !motor_pos_pin_o && !motor_neg_pin_o)
    else $error("motor pins active under no-load");
  supply_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sup_s2_r |=> wd_out_r)
    else $error("watchdog low with supply low");
  wd_pulse_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(wd_out_r) && $past(wd_state_r) == WD_PULSE
    |-> $past(wd_cnt_r) == WD_PULSE_CYC - 29'h1)
    else $error("watchdog pulse wrong length");
  wd_restart_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wd_state_r == WD_COUNT && latch_edge && !sup_s2_r
    |=> wd_cnt_r == 29'h0 && !wd_out_r)
    else $error("latch request did not restart watchdog");
  periph_map_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cfg_i.app_mode_sel == 2'h0 |=> motor_pos_pin_o == $past(zero_cross_sig_i)
    && motor_neg_pin_o == wd_out_r)
    else $error("peripheral pin mapping wrong");
  led_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cfg_i.app_mode_sel != 2'h0 |=> energy_pulse_pin_o ==
    $past(pulses[{cfg_i.reactive_len_sel, cfg_i.harmonic_only_sel, 2'h0}]))
    else $error("pulse pin source wrong in stepper mode");
  coil_excl_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !(motor_pos_pin_o && motor_neg_pin_o) || !step_mode)
    else $error("both coils driven");
  neg_block_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    p3_neg_r && cfg_i.neg_power_mode == 2'h0 |-> !step_fire
    ##1 step_state_r == STEP_IDLE)
    else $error("stepper ran on negative 3-phase power");
  serial_only_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !cfg_i.app_mode_sel[1] |=> serial_comm_only_o)
    else $error("peripheral flag not shown");

endmodule // energy_pulse_output_select

// >>> epo_defines.svh
// Constants for the energy pulse output select block
`ifndef EPO_DEFINES_SVH
`define EPO_DEFINES_SVH

`define EPO_ACC_W 20
`define EPO_STEP_BIT 10
`define EPO_CLK_MHZ 250

`define EPO_WD_PERIOD_MS 1600
`define EPO_WD_PULSE_MS 16
`define EPO_STEP_SHORT_US 31250
`define EPO_STEP_LONG_US 156250

`define EPO_WD_PERIOD_CYC (`EPO_WD_PERIOD_MS * 1000 * `EPO_CLK_MHZ)
`define EPO_WD_PULSE_CYC (`EPO_WD_PULSE_MS * 1000 * `EPO_CLK_MHZ)
`define EPO_STEP_SHORT_CYC (`EPO_STEP_SHORT_US * `EPO_CLK_MHZ)
`define EPO_STEP_LONG_CYC (`EPO_STEP_LONG_US * `EPO_CLK_MHZ)

`define EPO_SYS_HALF_LSB 3'h3
`define EPO_MODE_PERIPH 2'h0
`define EPO_NEG_FERRARIS3 2'h0
`define EPO_NEG_ABSOLUTE 2'h1
`define EPO_NEG_FERRARIS1 2'h2
`define EPO_NEG_SIGNED 2'h3

`define EPO_DIV_K0 12'h040
`define EPO_DIV_K1 12'h080
`define EPO_DIV_K2 12'h020
`define EPO_DIV_K3 12'h100
`define EPO_DIV_LONG_MULT 12'h00A

`endif

// >>> epo_pkg.sv
// Types shared by the energy pulse output select block
package epo_pkg;

  typedef struct packed {
    logic [1:0] app_mode_sel;
    logic [1:0] motor_ratio_sel;
    logic reactive_len_sel;
    logic harmonic_only_sel;
    logic [1:0] neg_power_mode;
    logic [2:0] topology;
  } cfg_s;

  // Per-phase powers, index 0..2 = R, S, T, two's complement
  typedef struct packed {
    logic [2:0][15:0] act;
    logic [2:0][15:0] harmonic_only_sel_act;
    logic [2:0][15:0] react;
    logic [2:0][15:0] harmonic_only_sel_react;
  } power_s;

  typedef enum logic [1:0] {WD_HOLD, WD_COUNT, WD_PULSE} wd_state_e;
  typedef enum logic {STEP_IDLE, STEP_ON} step_state_e;

endpackage

// >>> energy_integrator.sv
// One 20-bit energy accumulator with pulse-per-step output
`timescale 1ns/1ps
`include "epo_defines.svh"
module energy_integrator (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic valid_i,
  input wire logic signed [17:0] inc_i,
  input wire logic bidir_i,
  input wire logic coarse_i,
  output logic [19:0] energy_o,
  output logic pulse_o
);
  logic [20:0] sum_r;
  logic [20:0] sum_nxt;
  logic pulse_r;
  logic pulse_nxt;
  logic crossed;

  always_comb
  begin
    sum_nxt = sum_r;
    pulse_nxt = 1'b0;
    crossed = 1'b0;
    if (valid_i)
    begin
      sum_nxt = sum_r + 21'(inc_i);
      crossed = sum_nxt[20:`EPO_STEP_BIT] != sum_r[20:`EPO_STEP_BIT];
      pulse_nxt = crossed && (!inc_i[17] || bidir_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sum_r <= 21'h000000;
      pulse_r <= 1'b0;
    end
    else
    begin
      sum_r <= sum_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  // doubled LSB weight, pulse rate unchanged
  assign energy_o = coarse_i ? sum_r[20:1] : sum_r[19:0];
  assign pulse_o = pulse_r;

  step_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pulse_o |-> $past(sum_r[20:10]) != sum_r[20:10])
    else $error("pulse without step crossing");

endmodule // energy_integrator

// >>> host_model.sv
// Host model issuing periodic result-latch requests
`timescale 1ns/1ps
module host_model #(
  parameter int GAP = 50
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  output logic serial_latch_pin_o
);
  int cnt_r;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r <= 0;
      serial_latch_pin_o <= 1'b0;
    end
    else if (run_i)
    begin
      cnt_r <= (cnt_r == GAP - 1) ? 0 : cnt_r + 1;
      // Held four cycles so the two-flop sync cannot miss it
      serial_latch_pin_o <= (cnt_r < 4);
    end
    else
    begin
      cnt_r <= 0;
      serial_latch_pin_o <= 1'b0;
    end
  end
endmodule // host_model

// >>> energy_pulse_output_select_test.sv
// Self-checking bench for the energy pulse output select block
`timescale 1ns/1ps
module energy_pulse_output_select_test;
  import epo_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  cfg_s cfg = '0;
  logic [3:0][2:0][15:0] pw = '0;
  logic pv = 1'b0;
  logic nl = 1'b0;
  logic zc = 1'b0;
  logic sl = 1'b0;
  logic host_run = 1'b0;
  logic cnt_clr = 1'b0;
  logic latch;
  logic energy_pulse_pin, mpos, mneg, comm;
  logic [19:0] energy;
  int fails = 0;
  int n_checks = 0;
  int n_led, n_pos, n_neg, k, e, n;
  int st_app[7] = '{1, 1, 1, 1, 3, 1, 2};
  int st_rat[7] = '{2, 0, 1, 3, 2, 2, 2};
  int st_lvs[7] = '{0, 0, 0, 0, 1, 0, 0};
  int st_nl[7] = '{0, 0, 0, 0, 0, 1, 0};
  int st_n[7] = '{257, 257, 257, 513, 641, 257, 257};
  int st_pos[7] = '{20, 10, 10, 10, 50, 0, 20};
  int st_neg[7] = '{20, 10, 0, 0, 0, 0, 20};
  logic [19:0] ng_e[4] = '{20'hFE7A0, 20'h08A20, 20'h038E0, 20'hFE7A0};
  int ng_p[4] = '{0, 34, 14, 7};

  always #2 clk_i = ~clk_i;

  energy_pulse_output_select #(
    .WD_PERIOD_CYC(29'h00000C8),
    .WD_PULSE_CYC(29'h0000014),
    .STEP_SHORT_CYC(26'h000000A),
    .STEP_LONG_CYC(26'h0000032)
  ) i_dut (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .cfg_i(cfg),
    .power_i(power_s'(pw)),
    .power_valid_i(pv),
    .no_load_flag_i(nl),
    .zero_cross_sig_i(zc),
    .supply_low_i(sl),
    .serial_latch_pin_i(latch),
    .energy_pulse_pin_o(energy_pulse_pin),
    .motor_pos_pin_o(mpos),
    .motor_neg_pin_o(mneg),
    .serial_comm_only_o(comm),
    .active_energy_o(energy)
  );

  host_model #(
    .GAP(50)
  ) i_host (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(host_run),
    .serial_latch_pin_o(latch)
  );

  // High cycles seen on the pulse pin and both motor pins; one owner, cleared on request
  always @(posedge clk_i)
  begin
    if (cnt_clr)
    begin
      n_led <= 0;
      n_pos <= 0;
      n_neg <= 0;
    end
    else
    begin
      n_led <= n_led + int'(energy_pulse_pin === 1'b1);
      n_pos <= n_pos + int'(mpos === 1'b1);
      n_neg <= n_neg + int'(mneg === 1'b1);
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("Checks made %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic do_reset;
    @(negedge clk_i);
    rst_b_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check("reset outputs", 32'({energy_pulse_pin, mpos, mneg, comm, energy}),
      32'h00300000);
    rst_b_i = 1'b1;
  endtask

  // Counting starts one edge after config so mode changes have landed
  task automatic send(input int cnt);
    @(negedge clk_i);
    cnt_clr = 1'b1;
    pv = 1'b1;
    @(negedge clk_i);
    cnt_clr = 1'b0;
    repeat (cnt - 1) @(negedge clk_i);
    pv = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic wait_lvl(input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while (mneg !== lvl)
    begin
      @(negedge clk_i);
      cnt++;
      if (cnt > bound)
      begin
        fails++;
        $display("CHECK FAILED watchdog pin wait expected %0d seen none", lvl);
        give_verdict();
      end
    end
  endtask

  task automatic end_test(input string name);
    $display("Test %s done", name);
  endtask

  initial
  begin
    for (int s = 0; s < 16; s++)
    begin
      cfg = '0;
      cfg.reactive_len_sel = s[3];
      cfg.harmonic_only_sel = s[2];
      cfg.motor_ratio_sel = s[1:0];
      cfg.topology = s[0] ? 3'h3 : 3'h0;
      k = s / 4;
      for (int i = 0; i < 3; i++)
        pw[3 - k][i] = 16'(16 * (3 * k + i + 1));
      do_reset();
      send(65);
      e = (s % 4 == 0) ? 9 * k + 6 : 3 * k + s % 4;
      check("pulse pin count", 32'(n_led), 32'(e));
      check("active energy", 32'(energy), 32'h00001860);
    end
    end_test("pulse pin select");
    for (int m = 0; m < 4; m++)
    begin
      cfg = '0;
      cfg.neg_power_mode = 2'(m);
      pw = '0;
      pw[3] = {16'h0040, 16'h00A0, 16'hFEC0};
      do_reset();
      send(65);
      check("signed energy", 32'(energy), 32'(ng_e[m]));
      check("negative power pulses", 32'(n_led), 32'(ng_p[m]));
    end
    end_test("negative power");
    for (int r = 0; r < 7; r++)
    begin
      cfg = '0;
      cfg.app_mode_sel = 2'(st_app[r]);
      cfg.motor_ratio_sel = 2'(st_rat[r]);
      cfg.reactive_len_sel = 1'(st_lvs[r]);
      nl = 1'(st_nl[r]);
      pw = '0;
      pw[3][0] = 16'h0200;
      pw[1][0] = 16'h0100;
      do_reset();
      send(st_n[r]);
      repeat (80) @(negedge clk_i);
      check("coil a cycles", 32'(n_pos), 32'(st_pos[r]));
      check("coil b cycles", 32'(n_neg), 32'(st_neg[r]));
      check("comm only", 32'(comm), 32'(st_app[r] < 2));
      // Reactive select picks the 3-phase Q train, a quarter of samples
      e = st_lvs[r] ? st_n[r] / 4 : (st_n[r] - 1) / 2;
      if (st_nl[r] == 0)
        check("pulse pin count", 32'(n_led), 32'(e));
    end
    nl = 1'b0;
    end_test("stepper");
    cfg = '0;
    pw = '0;
    do_reset();
    wait_lvl(1'b0, 10, n);
    wait_lvl(1'b1, 400, n);
    check("watchdog low cycles", 32'(n), 32'd180);
    wait_lvl(1'b0, 100, n);
    check("watchdog high cycles", 32'(n), 32'd20);
    zc = 1'b1;
    @(negedge clk_i);
    check("zero cross high", 32'(mpos), 32'h1);
    zc = 1'b0;
    @(negedge clk_i);
    check("zero cross low", 32'(mpos), 32'h0);
    host_run = 1'b1;
    cnt_clr = 1'b1;
    @(negedge clk_i);
    cnt_clr = 1'b0;
    repeat (399) @(negedge clk_i);
    check("watchdog with latches", 32'(n_neg), 32'h0);
    host_run = 1'b0;
    wait_lvl(1'b1, 200, n);
    check("watchdog after latches", 32'(mneg), 32'h1);
    wait_lvl(1'b0, 100, n);
    sl = 1'b1;
    repeat (4) @(negedge clk_i);
    check("supply low forces high", 32'(mneg), 32'h1);
    repeat (300) @(negedge clk_i);
    check("supply low still high", 32'(mneg), 32'h1);
    sl = 1'b0;
    wait_lvl(1'b0, 30, n);
    check("supply back restarts", 32'(mneg), 32'h0);
    end_test("watchdog");
    give_verdict();
  end
endmodule // energy_pulse_output_select_test
